//--- core/index_pkg.sv
package index_pkg;

  // Register-bus offsets (byte addresses).
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_FIELD_A = 8'h08;
  localparam logic [7:0] OFF_FIELD_B = 8'h0c;
  localparam logic [7:0] OFF_STORE_ADDR = 8'h10;

  // Control register bit positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_DOUBLE_BIT = 1;
  localparam int CTRL_NOINDEX_OP_BIT = 2;

  // Index register storage layout.
  localparam int DIGITS = 5;
  localparam int REG_COUNT = 15;
  localparam logic [16:0] REG_BASE = 17'd25;
  localparam int REG_SPAN = 5;
  localparam logic [16:0] REG_LAST = 17'd99;

  // Character bit layout on the storage and B channel.
  localparam int CH_BIT_WM = 7;
  localparam int CH_BIT_B = 5;
  localparam int CH_BIT_A = 4;
  localparam logic [3:0] DIGIT_NINE = 4'h9;
  localparam logic [3:0] DIGIT_ZERO = 4'h0;
  localparam logic [3:0] DIGIT_TEN = 4'ha;

  // Tag weights for the register number.
  localparam int TAG_W_HB = 3;
  localparam int TAG_W_HA = 2;
  localparam int TAG_W_TB = 1;
  localparam int TAG_W_TA = 0;

  // Instruction ring steps at which an address digit is loaded.
  localparam logic [4:0] RING_A_UNITS = 5'd5;
  localparam logic [4:0] RING_B_UNITS = 5'd10;
  localparam logic [4:0] RING_A_HUND = 5'd3;
  localparam logic [4:0] RING_A_TENS = 5'd4;
  localparam logic [4:0] RING_B_HUND = 5'd8;
  localparam logic [4:0] RING_B_TENS = 5'd9;

  // Logic-clock gate length in hclk cycles.
  localparam logic [2:0] GATE_DIV = 3'd4;

  // Position ring, one-hot, seven bits: idle plus six positions.
  typedef enum logic [6:0] {
    POS_IDLE = 7'b0000001,
    POS_1 = 7'b0000010,
    POS_2 = 7'b0000100,
    POS_3 = 7'b0001000,
    POS_4 = 7'b0010000,
    POS_5 = 7'b0100000,
    POS_6 = 7'b1000000
  } pos_t;

  // Index cycle control state, one-hot.
  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001,
    CY_FETCH = 4'b0010,
    CY_ADD = 4'b0100,
    CY_UPDATE = 4'b1000
  } cycle_t;

  // Tag latches for one tag digit position.
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } tag_t;

  // Storage request to core.
  typedef struct packed {
    logic req;
    logic [16:0] addr;
  } stor_req_t;

endpackage

//--- core/digit_adder.sv
`timescale 1ns/1ps

// One decimal digit of the algebraic index addition.
module digit_adder (
  // Operands
  input wire logic [3:0] a_digit,
  input wire logic [3:0] b_digit,
  input wire logic complement,
  input wire logic carry_in,
  // Result
  output logic [3:0] sum,
  output logic carry_out
);

  logic [4:0] raw;
  logic [3:0] b_eff;

  // Nines complement of the register digit when its sign is minus.
  always_comb begin
    b_eff = complement ? (index_pkg::DIGIT_NINE - b_digit) : b_digit;
    raw = {1'b0, a_digit} + {1'b0, b_eff} + {4'h0, carry_in};
    if (raw >= {1'b0, index_pkg::DIGIT_TEN}) begin
      sum = 4'((raw - {1'b0, index_pkg::DIGIT_TEN}));
      carry_out = 1'b1;
    end else begin
      sum = raw[3:0];
      carry_out = 1'b0;
    end
  end

endmodule

//--- core/index_address_modifier.sv
`timescale 1ns/1ps

module index_address_modifier #(
  parameter int DIGITS = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Instruction read-out inputs
  input wire logic [4:0] i_ring,
  input wire logic i_cycle,
  input wire logic [7:0] assembly_char,
  // Core storage port
  input wire logic [7:0] b_channel,
  input wire logic b_valid,
  output logic stor_req,
  output logic [16:0] stor_addr,
  // Instruction read-out control
  output logic hold_i_ring,
  output logic index_busy
);

  //////////////////////////////////////////////////////////////////////////////
  // Register bus.

  logic [31:0] ctrl_ff;
  logic [19:0] field_a_ff;
  logic [19:0] field_b_ff;
  logic [19:0] a_oper_ff;
  logic [19:0] b_oper_ff;
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [31:0] status_w;
  logic bus_go;

  assign bus_go = hsel && hready && htrans[1];

  // Address phase capture; the slave answers with zero wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= bus_go && hwrite;
      if (bus_go) begin
        wr_addr_ff <= haddr;
      end
    end
  end

  // Read data mux, registered so the output stands from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (bus_go && !hwrite) begin
        case (haddr)
          index_pkg::OFF_CTRL: hrdata <= ctrl_ff;
          index_pkg::OFF_STATUS: hrdata <= status_w;
          index_pkg::OFF_FIELD_A: hrdata <= {12'h0, field_a_ff};
          index_pkg::OFF_FIELD_B: hrdata <= {12'h0, field_b_ff};
          index_pkg::OFF_STORE_ADDR: hrdata <= {12'h0, a_oper_ff};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gate divider: one enable pulse per logic gate.

  logic [2:0] div_ff;
  logic gate_tick;

  assign gate_tick = (div_ff == index_pkg::GATE_DIV - 3'd1);

  // Free-running logic-gate divider.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= gate_tick ? 3'h0 : div_ff + 3'd1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Tag latches and register number.

  index_pkg::tag_t hund_tag_ff;
  index_pkg::tag_t tens_tag_ff;
  logic [3:0] reg_num;
  logic index_required;
  logic index_allowed;
  logic [2:0] zone_odd_c;

  assign index_allowed = ctrl_ff[index_pkg::CTRL_ENABLE_BIT]
      && !ctrl_ff[index_pkg::CTRL_NOINDEX_OP_BIT];
  // C bit keeps zone count odd
  assign zone_odd_c = {assembly_char[index_pkg::CH_BIT_A], assembly_char[index_pkg::CH_BIT_B],
      ~(assembly_char[index_pkg::CH_BIT_A] ^ assembly_char[index_pkg::CH_BIT_B])};
  assign reg_num = {hund_tag_ff.b, hund_tag_ff.a, tens_tag_ff.b, tens_tag_ff.a};
  assign index_required = hund_tag_ff.a || hund_tag_ff.b || tens_tag_ff.a || tens_tag_ff.b;

  index_pkg::cycle_t cyc_ff;
  index_pkg::pos_t pos_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hund_tag_ff <= '0;
      tens_tag_ff <= '0;
    end else if (cyc_ff == index_pkg::CY_UPDATE && gate_tick) begin
      hund_tag_ff <= '0;
      tens_tag_ff <= '0;
    end else if (i_cycle && gate_tick && cyc_ff == index_pkg::CY_IDLE) begin
      // Tags of a never-indexed op load as zero, so stale tags cannot start a run.
      if (i_ring == index_pkg::RING_A_HUND || i_ring == index_pkg::RING_B_HUND) begin
        hund_tag_ff <= index_allowed ? zone_odd_c : 3'h0;
      end
      if (i_ring == index_pkg::RING_A_TENS || i_ring == index_pkg::RING_B_TENS) begin
        tens_tag_ff <= index_allowed ? zone_odd_c : 3'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Index cycle sequencing.

  logic b_side_ff;
  logic carry_ff;
  logic neg_ff;
  logic start_ok;
  logic [2:0] digit_idx;
  logic [16:0] digit_addr;

  // start at step 5/10, no word mark
  assign start_ok = i_cycle && index_required && !b_channel[index_pkg::CH_BIT_WM]
      && (i_ring == index_pkg::RING_A_UNITS || i_ring == index_pkg::RING_B_UNITS);

  always_comb begin
    case (pos_ff)
      index_pkg::POS_1: digit_idx = 3'd0;
      index_pkg::POS_2: digit_idx = 3'd1;
      index_pkg::POS_3: digit_idx = 3'd2;
      index_pkg::POS_4: digit_idx = 3'd3;
      index_pkg::POS_5: digit_idx = 3'd4;
      default: digit_idx = 3'd0;
    endcase
  end

  // next digit from ring and tags
  assign digit_addr = index_pkg::REG_BASE + 17'(index_pkg::REG_SPAN) * 17'(reg_num - 4'd1)
      + 17'(index_pkg::REG_SPAN - 1) - 17'(digit_idx);

  // Ring and cycle control.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_ff <= index_pkg::CY_IDLE;
      pos_ff <= index_pkg::POS_IDLE;
      b_side_ff <= 1'b0;
    end else if (gate_tick) begin
      case (cyc_ff)
        index_pkg::CY_IDLE: begin
          if (start_ok) begin
            cyc_ff <= index_pkg::CY_FETCH;
            pos_ff <= index_pkg::POS_1;
            b_side_ff <= (i_ring == index_pkg::RING_B_UNITS);
          end
        end
        index_pkg::CY_FETCH: begin
          if (b_valid) begin
            cyc_ff <= index_pkg::CY_ADD;
          end
        end
        index_pkg::CY_ADD: begin
          if (pos_ff == index_pkg::POS_5) begin
            pos_ff <= index_pkg::POS_6;
            cyc_ff <= index_pkg::CY_UPDATE;
          end else begin
            pos_ff <= index_pkg::pos_t'({pos_ff[5:0], 1'b0});
            cyc_ff <= index_pkg::CY_FETCH;
          end
        end
        index_pkg::CY_UPDATE: begin
          cyc_ff <= index_pkg::CY_IDLE;
          pos_ff <= index_pkg::POS_IDLE;
        end
        default: begin
          cyc_ff <= index_pkg::CY_IDLE;
          pos_ff <= index_pkg::POS_IDLE;
        end
      endcase
    end
  end

  // Storage request and hold outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stor_req <= 1'b0;
      stor_addr <= 17'h0;
      hold_i_ring <= 1'b0;
      index_busy <= 1'b0;
    end else begin
      // reads only, storage never written
      // The request stands through the add so the digit stays on the B channel.
      stor_req <= (cyc_ff == index_pkg::CY_FETCH) || (cyc_ff == index_pkg::CY_ADD);
      stor_addr <= digit_addr;
      hold_i_ring <= (cyc_ff != index_pkg::CY_IDLE) || start_ok;
      index_busy <= (cyc_ff != index_pkg::CY_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Digit adder.

  logic [3:0] a_digit;
  logic [3:0] sum_digit;
  logic carry_out;
  logic [19:0] src_field;
  logic complement;

  assign src_field = b_side_ff ? field_b_ff : field_a_ff;
  assign a_digit = src_field[4 * digit_idx +: 4];
  assign complement = (pos_ff == index_pkg::POS_1) ?
      (b_channel[index_pkg::CH_BIT_B] && !b_channel[index_pkg::CH_BIT_A]) : neg_ff;

  digit_adder u_add (
    .a_digit(a_digit),
    .b_digit(b_channel[3:0]),
    .complement(complement),
    .carry_in((pos_ff == index_pkg::POS_1) ? complement : carry_ff),
    .sum(sum_digit),
    .carry_out(carry_out)
  );

  // Carry and sign between digits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_ff <= 1'b0;
      neg_ff <= 1'b0;
    end else if (gate_tick && cyc_ff == index_pkg::CY_ADD) begin
      carry_ff <= carry_out;
      if (pos_ff == index_pkg::POS_1) begin
        neg_ff <= complement;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address registers and control register.

  assign status_w = {9'h0, pos_ff, 4'h0, reg_num, cyc_ff, 3'h0, b_side_ff};

  // Software writes and indexed results.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= 32'h1;
      field_a_ff <= 20'h0;
      field_b_ff <= 20'h0;
      a_oper_ff <= 20'h0;
      b_oper_ff <= 20'h0;
    end else begin
      if (wr_pend_ff) begin
        case (wr_addr_ff)
          index_pkg::OFF_CTRL: ctrl_ff <= hwdata;
          index_pkg::OFF_FIELD_A: field_a_ff <= hwdata[19:0];
          index_pkg::OFF_FIELD_B: field_b_ff <= hwdata[19:0];
          default: ;
        endcase
      end
      if (gate_tick && cyc_ff == index_pkg::CY_ADD) begin
        if (b_side_ff) begin
          b_oper_ff[4 * digit_idx +: 4] <= sum_digit;
        end else begin
          a_oper_ff[4 * digit_idx +: 4] <= sum_digit;
          if (ctrl_ff[index_pkg::CTRL_DOUBLE_BIT]) begin
            b_oper_ff[4 * digit_idx +: 4] <= sum_digit;
          end
        end
      end
      // update writes the A or B field, and the B field as well when double is set on an A run
      if (gate_tick && cyc_ff == index_pkg::CY_UPDATE) begin
        if (b_side_ff) begin
          field_b_ff <= b_oper_ff;
        end else begin
          field_a_ff <= a_oper_ff;
          if (ctrl_ff[index_pkg::CTRL_DOUBLE_BIT]) begin
            field_b_ff <= a_oper_ff;
          end
        end
      end
    end
  end

endmodule

//--- testbench/index_address_modifier_asserts.sv
`timescale 1ns/1ps

// Watches the indexing outputs of the modifier.
module index_checker #(
  parameter int DIGITS = 5
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Observed ports
  input wire logic [4:0] i_ring,
  input wire logic i_cycle,
  input wire logic stor_req,
  input wire logic [16:0] stor_addr,
  input wire logic hold_i_ring,
  input wire logic index_busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] dig_ff;
  logic [16:0] last_ff;

  // Counts the distinct digit addresses of one run.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dig_ff <= 4'h0;
      last_ff <= 17'h0;
    end else if (stor_req && stor_addr != last_ff) begin
      dig_ff <= dig_ff + 4'h1;
      last_ff <= stor_addr;
    end else if (!stor_req && !index_busy) begin
      dig_ff <= 4'h0;
      last_ff <= 17'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_range;
    stor_req |-> stor_addr >= 17'd25 && stor_addr <= 17'd99;
  endproperty
  a_range: assert property (p_range)
    else $error("digit address outside register area");
  property p_units;
    $rose(stor_req) |-> stor_addr % 17'd5 == 17'd4;
  endproperty
  a_units: assert property (p_units)
    else $error("first fetch is not a units digit");
  property p_descend;
    stor_req && $past(stor_req) && stor_addr != $past(stor_addr)
      |-> stor_addr == $past(stor_addr) - 17'd1;
  endproperty
  a_descend: assert property (p_descend)
    else $error("digit address did not step down by one");
  property p_start;
    $rose(stor_req) |-> i_cycle && (i_ring == 5'd5 || i_ring == 5'd10);
  endproperty
  a_start: assert property (p_start)
    else $error("fetch began outside units step");
  property p_busy;
    stor_req |-> index_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("fetch without busy");
  property p_hold;
    $rose(hold_i_ring) |-> $past(i_ring) == 5'd5 || $past(i_ring) == 5'd10;
  endproperty
  a_hold: assert property (p_hold)
    else $error("ring held outside units step");
  property p_count;
    $fell(index_busy) |-> dig_ff == DIGITS;
  endproperty
  a_count: assert property (p_count)
    else $error("wrong number of digits fetched");
  property p_done;
    $rose(index_busy) |-> ##[1:600] !index_busy;
  endproperty
  a_done: assert property (p_done)
    else $error("indexing run did not finish");
  property p_clear;
    $fell(index_busy) |-> !stor_req [*2];
  endproperty
  a_clear: assert property (p_clear)
    else $error("fetch continued after run");

  // Main scenarios reached.
  c_run: cover property ($fell(index_busy));
  c_hold: cover property ($rose(hold_i_ring));
  c_top: cover property (stor_req && stor_addr == 17'd99);
endmodule

bind index_address_modifier index_checker #(.DIGITS(DIGITS)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .i_ring(i_ring), .i_cycle(i_cycle),
  .stor_req(stor_req), .stor_addr(stor_addr), .hold_i_ring(hold_i_ring),
  .index_busy(index_busy));

//--- testbench/core_store_model.sv
`timescale 1ns/1ps

// Core storage holding index registers and the instruction stream.
module core_store_model (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Requests
  input wire logic stor_req,
  input wire logic [16:0] stor_addr,
  // Bench controls
  input wire logic [7:0] instr_char,
  input wire logic slow,
  // Answer
  output logic [7:0] b_channel,
  output logic b_valid
);
  logic [7:0] mem [0:99];
  logic [16:0] addr_ff;
  logic [2:0] wait_ff;
  logic [7:0] last_ff;

  // read only port
  // Counts cycles on one address; there is no write path at all.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff <= 17'h0;
      wait_ff <= 3'h0;
      last_ff <= 8'h00;
    end else begin
      addr_ff <= stor_addr;
      if (!stor_req || stor_addr != addr_ff) wait_ff <= 3'h0;
      else if (wait_ff != 3'h7) wait_ff <= wait_ff + 3'h1;
      if (b_valid) last_ff <= b_channel;
    end
  end

  // plain storage
  // Stale lines show the inverse of the last character, never a held value.
  always_comb begin
    b_valid = stor_req && stor_addr == addr_ff && wait_ff >= (slow ? 3'h5 : 3'h0);
    if (b_valid && stor_addr < 17'd100) b_channel = mem[stor_addr[6:0]];
    else if (stor_req) b_channel = ~last_ff;
    else b_channel = instr_char;
  end
endmodule

//--- testbench/test_index_address_modifier.sv
`timescale 1ns/1ps

// Self-checking bench for the index address modifier.
module test_index_address_modifier;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, b_valid, stor_req, hold_i_ring, index_busy, saw_hold;
  logic [4:0] i_ring = 5'h0;
  logic i_cycle = 1'b0;
  logic [7:0] assembly_char = 8'h00;
  logic [7:0] instr_char = 8'h00;
  logic slow = 1'b0;
  logic [7:0] b_channel;
  logic [16:0] stor_addr;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Clock at 125 MHz.
  always #4 hclk = ~hclk;

  index_address_modifier i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .i_ring(i_ring), .i_cycle(i_cycle), .assembly_char(assembly_char),
    .b_channel(b_channel), .b_valid(b_valid), .stor_req(stor_req),
    .stor_addr(stor_addr), .hold_i_ring(hold_i_ring), .index_busy(index_busy));
  core_store_model i_stor (.hclk(hclk), .hresetn(hresetn), .stor_req(stor_req),
    .stor_addr(stor_addr), .instr_char(instr_char), .slow(slow),
    .b_channel(b_channel), .b_valid(b_valid));

  ////////////////////////////////////////////////////////////////////////////
  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite word transfer.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // Decimal sum of address and signed register, five digits kept.
  function automatic logic [19:0] bcd_add(logic [19:0] a, logic [19:0] r, logic neg);
    int x = 0;
    int y = 0;
    int i;
    for (i = 4; i >= 0; i--) begin
      x = x * 10 + int'(a[i*4+:4]);
      y = y * 10 + int'(r[i*4+:4]);
    end
    x = neg ? (x + 100000 - y) % 100000 : (x + y) % 100000;
    for (i = 0; i < 5; i++) begin
      bcd_add[i*4+:4] = 4'(x % 10);
      x = x / 10;
    end
  endfunction

  // Loads a register; word marks and upper zones are noise to be ignored.
  task automatic set_reg(input int n, input logic [19:0] v, input logic neg);
    int k;
    for (k = 0; k < 5; k++) begin
      i_stor.mem[25 + 5 * (n - 1) + 4 - k] =
        {k == 1 || k == 3, 1'b0, k == 0 || k == 3, k == 0 && !neg, v[k*4+:4]};
    end
  endtask

  // Presents one instruction ring step for two gate periods.
  task automatic step(input logic [4:0] r, input logic [7:0] c);
    @(posedge hclk);
    i_cycle <= 1'b1;
    i_ring <= r;
    assembly_char <= c;
    repeat (8) @(posedge hclk);
  endtask

  // Reads out hundreds, tens and units of one address field.
  task automatic run(input logic bs, input logic [3:0] n, input logic wm);
    int t;
    instr_char <= {wm, 7'h05};
    step(bs ? 5'd8 : 5'd3, {2'b00, n[3:2], 4'h1});
    step(bs ? 5'd9 : 5'd4, {2'b00, n[1:0], 4'h2});
    step(bs ? 5'd10 : 5'd5, 8'h03);
    saw_hold = hold_i_ring;
    t = 0;
    while ((hold_i_ring !== 1'b0 || index_busy !== 1'b0) && t < 800) begin
      @(posedge hclk);
      t++;
    end
    chk(32'(t < 800), 32'h1);
    i_ring <= 5'd0;
    i_cycle <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  // Runs one indexed or plain field and checks every result.
  task automatic do_case(input logic [3:0] n, input logic [19:0] v, input logic neg,
      input logic [19:0] ad, input logic bs, input logic [2:0] ctl, input logic wm,
      input logic ix);
    logic [31:0] rd;
    logic [19:0] e;
    e = ix ? bcd_add(ad, v, neg) : ad;
    if (n != 4'h0) set_reg(n, v, neg);
    bus(1'b1, index_pkg::OFF_CTRL, {29'h0, ctl}, rd);
    bus(1'b1, bs ? index_pkg::OFF_FIELD_B : index_pkg::OFF_FIELD_A, {12'h0, ad}, rd);
    run(bs, n, wm);
    chk({31'h0, saw_hold}, {31'h0, ix});
    bus(1'b0, bs ? index_pkg::OFF_FIELD_B : index_pkg::OFF_FIELD_A, 32'h0, rd);
    chk(rd, {12'h0, e});
    if (ctl[1]) begin
      bus(1'b0, index_pkg::OFF_FIELD_B, 32'h0, rd);
      chk(rd, {12'h0, e});
    end
    if (ix && !bs) begin
      bus(1'b0, index_pkg::OFF_STORE_ADDR, 32'h0, rd);
      chk(rd, {12'h0, e});
    end
    bus(1'b0, index_pkg::OFF_STATUS, 32'h0, rd);
    chk(32'({rd[22:16], rd[11:4]}), {17'h0, 7'h01, (ix || ctl[2]) ? 4'h0 : n, 4'h1});
  endtask

  // Cuts a hung run short.
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      print_verdict;
    end
  end

  // Main sequence.
  initial begin
    logic [31:0] rd;
    int n;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, index_pkg::OFF_CTRL, 32'h0, rd);
    chk(rd, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff, rd);
    bus(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0);
    for (n = 1; n < 16; n++) begin
      slow <= n[1];
      do_case(4'(n), 20'(n + (n > 9) * 6), n[0], 20'h00500, n[2], 3'h1, 1'b0, 1'b1);
    end
    do_case(4'd15, 20'h00005, 1'b1, 20'h00003, 1'b0, 3'h1, 1'b0, 1'b1);
    do_case(4'd2, 20'h99999, 1'b0, 20'h00001, 1'b1, 3'h1, 1'b0, 1'b1);
    do_case(4'd10, 20'h12345, 1'b1, 20'h50000, 1'b0, 3'h3, 1'b0, 1'b1);
    do_case(4'd0, 20'h00000, 1'b0, 20'h00042, 1'b0, 3'h1, 1'b0, 1'b0);
    do_case(4'd7, 20'h00011, 1'b0, 20'h00100, 1'b0, 3'h5, 1'b0, 1'b0);
    do_case(4'd9, 20'h00011, 1'b0, 20'h00100, 1'b1, 3'h1, 1'b1, 1'b0);
    print_verdict;
  end
endmodule
